// *** hw/cfg_front.sv ***
/*
 * Configuration front end of a data converter: pin-strap decode, the
 * write-only three-wire serial port, soft and hardware register reset,
 * power-up settling flag and an AXI4-Lite slave for supervision.
 * Assumes all pins are asynchronous to aclk and the serial clock is well
 * below half the system clock rate.
 */
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module cfg_front #(
   parameter int POWERUP_CYCLES = cfg_pkg::POWERUP_CYCLES
) (
   // System clock and synchronous active-low reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data.
   input wire logic [cfg_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address and data.
   input wire logic [cfg_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Converter control pins.
   input wire logic reset_pin,
   input wire logic serial_select_n,
   input wire logic serial_clock,
   input wire logic serial_input_line,
   input wire logic power_down,
   // Strap level codes sensed on the clock and select pins.
   input wire logic [1:0] clk_level,
   input wire logic [1:0] sel_level,
   // Effective configuration and settling flag.
   output cfg_pkg::cfg_out_s cfg,
   output logic output_stable
);
   import cfg_pkg::*;

   localparam int PU_W = $clog2(POWERUP_CYCLES + 1);
   localparam logic [PU_W-1:0] PU_LAST = PU_W'(POWERUP_CYCLES);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.
   cfg_pins_s pins_raw;
   cfg_pins_s pins;

   assign pins_raw = '{reset_pin: reset_pin,
                       serial_select_n: serial_select_n,
                       serial_clock: serial_clock,
                       serial_input_line: serial_input_line,
                       power_down: power_down,
                       clk_level: clk_level,
                       sel_level: sel_level};

   cfg_sync #(
      .W($bits(cfg_pins_s))
   ) u_sync (
      .aclk(aclk),
      .din(pins_raw),
      .dout(pins)
   );

   ////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic sclk_prev;
   logic [14:0] shift;
   logic [3:0] bit_cnt;
   logic ctrl_enable;
   logic [REG_ADDR_BITS-1:0] view_index;
   logic [COUNT_W-1:0] word_count;
   logic [REG_DATA_BITS-1:0] reg_main;
   logic [REG_DATA_BITS-1:0] reg_format;
   logic [REG_DATA_BITS-1:0] view_data;
   logic [PU_W-1:0] pu_cnt;
   logic aw_held;
   logic w_held;
   logic [AXI_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   ////////////////////////////////////////////////////////////////////////
   // Mode and serial word assembly.
   wire strap_mode = pins.reset_pin;
   wire port_open = ~strap_mode & ctrl_enable & ~pins.serial_select_n;
   wire sclk_fall = sclk_prev & ~pins.serial_clock;
   wire shift_now = port_open & sclk_fall;
   wire commit = shift_now & (bit_cnt == LAST_BIT);
   wire [WORD_BITS-1:0] word = {shift, pins.serial_input_line};
   wire [REG_ADDR_BITS-1:0] word_addr = word[WORD_BITS-1:REG_DATA_BITS];
   wire [REG_DATA_BITS-1:0] word_data = word[REG_DATA_BITS-1:0];
   wire soft_reset = commit & (word_addr == REG_MAIN)
                   & word_data[R0_SOFT_RESET];
   wire regs_clear = ~aresetn | pins.reset_pin | soft_reset;
   wire regs_write = commit & ~soft_reset;

   // Sample the serial clock level to find its falling edges.
   always_ff @(posedge aclk) begin
      sclk_prev <= aresetn ? pins.serial_clock : 1'h0;
   end

   // Bit counter restarts whenever the port closes, dropping any tail.
   always_ff @(posedge aclk) begin
      if (!aresetn || !port_open) begin
         bit_cnt <= 4'h0;
      end else if (shift_now) begin
         bit_cnt <= 4'(bit_cnt + 4'h1);
      end
   end

   // Shift register takes one data bit per falling edge.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift <= 15'h0000;
      end else if (shift_now) begin
         shift <= word[14:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register store; the soft reset bit itself is never stored.
   cfg_regmem #(
      .AW(REG_ADDR_BITS),
      .DW(REG_DATA_BITS),
      .INIT(REG_DEFAULT)
   ) u_mem (
      .aclk(aclk),
      .clear(regs_clear),
      .wr_en(regs_write),
      .wr_addr(word_addr),
      .wr_data(word_data),
      .rd_addr(view_index),
      .rd_data(view_data)
   );

   // Live copies of the two registers that steer the outputs.
   always_ff @(posedge aclk) begin
      if (regs_clear) begin
         reg_main <= REG_DEFAULT;
      end else if (regs_write && word_addr == REG_MAIN) begin
         reg_main <= word_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (regs_clear) begin
         reg_format <= REG_DEFAULT;
      end else if (regs_write && word_addr == REG_FORMAT) begin
         reg_format <= word_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Strap decode.
   wire cfg_power_e power_state = cfg_power_e'({pins.serial_input_line,
                                                pins.power_down});
   wire strap_ref_ext = (pins.clk_level == LVL_3_8)
                      | (pins.clk_level == LVL_5_8);
   wire strap_gain = (pins.clk_level == LVL_5_8)
                   | (pins.clk_level == LVL_RAIL);
   wire strap_binary = (pins.sel_level == LVL_3_8)
                     | (pins.sel_level == LVL_5_8);
   wire strap_cmos = (pins.sel_level == LVL_5_8)
                   | (pins.sel_level == LVL_RAIL);

   cfg_out_s strap_cfg;
   cfg_out_s serial_cfg;

   // Power straps: standby, output buffers only, or global power-down with standby and buffers; clkout_pdn stays low.
   assign strap_cfg = '{ref_external: strap_ref_ext,
                        coarse_gain: strap_gain,
                        straight_binary: strap_binary,
                        iface_cmos: strap_cmos,
                        adc_standby: (power_state == PWR_STANDBY)
                                     | (power_state == PWR_GLOBAL),
                        obuf_pdn: (power_state == PWR_OBUF)
                                  | (power_state == PWR_GLOBAL),
                        clkout_pdn: 1'h0,
                        global_pdn: power_state == PWR_GLOBAL};

   // Serial mode takes every field but global_pdn, held low, from the written registers.
   assign serial_cfg = '{ref_external: reg_main[R0_REF],
                         coarse_gain: reg_main[R0_COARSE],
                         straight_binary: reg_format[RF_STRAIGHT],
                         iface_cmos: reg_main[R0_CMOS],
                         adc_standby: reg_main[R0_STBY],
                         obuf_pdn: reg_main[R0_OBUF_PDN],
                         clkout_pdn: reg_main[R0_CLKOUT_PDN],
                         global_pdn: 1'h0};

   // Configuration output is registered.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= '0;
      end else begin
         cfg <= strap_mode ? strap_cfg : serial_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-up settling counter; data before the flag must be ignored.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pu_cnt <= '0;
         output_stable <= 1'h0;
      end else if (pu_cnt != PU_LAST) begin
         pu_cnt <= PU_W'(pu_cnt + 1'b1);
      end else begin
         output_stable <= 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data taken in either order.
   wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
   wire [AXI_ADDR_W-1:0] wr_word = {aw_addr[AXI_ADDR_W-1:2], 2'b00};
   wire wr_ctrl = wr_word == OFF_CTRL;
   wire wr_index = wr_word == OFF_VIEW_INDEX;
   wire wr_ro = (wr_word == OFF_STATUS) | (wr_word == OFF_CONFIG)
              | (wr_word == OFF_VIEW_DATA);
   wire wr_lane0 = wr_fire & w_strb[0];
   wire count_clear = wr_lane0 & wr_ctrl & w_data[CTRL_CLEAR_BIT];

   // Write address channel.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'h0;
         s_axi_awready <= 1'h1;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'h1;
         s_axi_awready <= 1'h0;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'h1;
      end
   end

   // Write data channel.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'h0;
         s_axi_wready <= 1'h1;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'h1;
         s_axi_wready <= 1'h0;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'h1;
      end
   end

   // Write response, error on an unmapped address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'h0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'h1;
         s_axi_bresp <= (wr_ctrl | wr_index | wr_ro) ? RESP_OKAY
                                                    : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'h0;
      end
   end

   // Software registers: port enable and view index.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_enable <= CTRL_ENABLE_RESET;
         view_index <= '0;
      end else if (wr_lane0 && wr_ctrl) begin
         ctrl_enable <= w_data[CTRL_ENABLE_BIT];
      end else if (wr_lane0 && wr_index) begin
         view_index <= w_data[REG_ADDR_BITS-1:0];
      end
   end

   // Committed word counter; a clear and a commit in the same cycle leave a count of one.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_count <= '0;
      end else if (commit) begin
         word_count <= count_clear ? COUNT_W'(1) : COUNT_W'(word_count + 1'b1);
      end else if (count_clear) begin
         word_count <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path.
   wire [AXI_ADDR_W-1:0] rd_word = {s_axi_araddr[AXI_ADDR_W-1:2], 2'b00};
   wire [31:0] status_word = {16'h0000, word_count, 5'h00,
                              port_open, output_stable, strap_mode};
   wire rd_hit = (rd_word == OFF_STATUS) | (rd_word == OFF_CONFIG)
               | (rd_word == OFF_CTRL) | (rd_word == OFF_VIEW_INDEX)
               | (rd_word == OFF_VIEW_DATA);
   wire [31:0] rd_value =
      (rd_word == OFF_STATUS) ? status_word :
      (rd_word == OFF_CONFIG) ? {24'h000000, cfg} :
      (rd_word == OFF_CTRL) ? {31'h00000000, ctrl_enable} :
      (rd_word == OFF_VIEW_INDEX) ? {27'h0000000, view_index} :
      (rd_word == OFF_VIEW_DATA) ? {21'h000000, view_data} :
      32'h0000_0000;

   // One read at a time; data captured when the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'h1;
         s_axi_rvalid <= 1'h0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid <= 1'h1;
         s_axi_rdata <= rd_value;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'h0;
         s_axi_arready <= 1'h1;
      end
   end

endmodule : cfg_front
`default_nettype wire

// *** hw/cfg_pkg.sv ***
/*
 * Shared constants and types for the converter configuration front end:
 * the register bus map, serial word layout, strap level codes, the fields
 * of the effective configuration and the power-up timing.
 * Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package cfg_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register bus map.
   localparam int AXI_ADDR_W = 8;
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_CONFIG = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_VIEW_INDEX = 8'h0c;
   localparam logic [7:0] OFF_VIEW_DATA = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control register fields and reset value.
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam logic CTRL_ENABLE_RESET = 1'h1;

   // Status register fields.
   localparam int ST_STRAP_BIT = 0;
   localparam int ST_STABLE_BIT = 1;
   localparam int ST_SELECT_BIT = 2;
   localparam int ST_COUNT_LSB = 8;
   localparam int COUNT_W = 8;

   ////////////////////////////////////////////////////////////////////////
   // Serial word layout: address first, then data, most significant first.
   localparam int WORD_BITS = 16;
   localparam int REG_ADDR_BITS = 5;
   localparam int REG_DATA_BITS = 11;
   localparam logic [3:0] LAST_BIT = 4'hf;
   localparam logic [4:0] REG_MAIN = 5'h00;
   localparam logic [4:0] REG_FORMAT = 5'h0a;
   localparam logic [10:0] REG_DEFAULT = 11'h000;

   // Field positions inside the main and format registers.
   localparam int R0_OBUF_PDN = 10;
   localparam int R0_COARSE = 9;
   localparam int R0_CMOS = 8;
   localparam int R0_REF = 5;
   localparam int R0_SOFT_RESET = 4;
   localparam int R0_CLKOUT_PDN = 2;
   localparam int R0_STBY = 0;
   localparam int RF_STRAIGHT = 10;

   ////////////////////////////////////////////////////////////////////////
   // Strap level codes from the multi-level pin comparators.
   localparam logic [1:0] LVL_GND = 2'h0;
   localparam logic [1:0] LVL_3_8 = 2'h1;
   localparam logic [1:0] LVL_5_8 = 2'h2;
   localparam logic [1:0] LVL_RAIL = 2'h3;

   // Power state chosen by the data and power-down straps.
   typedef enum logic [1:0] {
      PWR_NORMAL = 2'b00,
      PWR_STANDBY = 2'b01,
      PWR_OBUF = 2'b10,
      PWR_GLOBAL = 2'b11
   } cfg_power_e;

   ////////////////////////////////////////////////////////////////////////
   // Power-up timing.
   localparam int CLK_HZ = 25_000_000;
   localparam int POWERUP_TIME_US = 6500;
   localparam int POWERUP_CYCLES = POWERUP_TIME_US * (CLK_HZ / 1_000_000);

   ////////////////////////////////////////////////////////////////////////
   // Effective configuration driven to the converter.
   typedef struct packed {
      logic ref_external;
      logic coarse_gain;
      logic straight_binary;
      logic iface_cmos;
      logic adc_standby;
      logic obuf_pdn;
      logic clkout_pdn;
      logic global_pdn;
   } cfg_out_s;

   // Pins from outside the clock domain, kept together for synchronising.
   typedef struct packed {
      logic reset_pin;
      logic serial_select_n;
      logic serial_clock;
      logic serial_input_line;
      logic power_down;
      logic [1:0] clk_level;
      logic [1:0] sel_level;
   } cfg_pins_s;

endpackage : cfg_pkg

// *** hw/cfg_regmem.sv ***
/*
 * Small register array holding the serially written configuration words.
 * Assumes one write port, one registered read port and a clear that
 * returns every word to its default in a single cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module cfg_regmem #(
   parameter int AW = 5,
   parameter int DW = 11,
   parameter logic [DW-1:0] INIT = '0
) (
   // Clock and clear to defaults.
   input wire logic aclk,
   input wire logic clear,
   // Write port.
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   // Registered read port.
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);

   logic [DW-1:0] mem [2**AW];

   // Clear wins over a write in the same cycle.
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 2**AW; i++) begin
         if (clear) begin
            mem[i] <= INIT;
         end else if (wr_en && wr_addr == AW'(i)) begin
            mem[i] <= wr_data;
         end
      end
   end

   // Read data come out of a register.
   always_ff @(posedge aclk) begin
      if (clear) begin
         rd_data <= INIT;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule : cfg_regmem
`default_nettype wire

// *** hw/cfg_sync.sv ***
/*
 * Two flip-flop synchroniser of parameterised width.
 * Assumes each bit is an independent level; multi-bit codes that change
 * together may show one mixed sample, which the user must tolerate.
 */
`timescale 1ns/1ns
`default_nettype none

module cfg_sync #(
   parameter int W = 1
) (
   // Clock.
   input wire logic aclk,
   // Asynchronous levels in, synchronised levels out.
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] meta;

   // First stage feeds only the second stage.
   always_ff @(posedge aclk) begin
      meta <= din;
      dout <= meta;
   end

endmodule : cfg_sync
`default_nettype wire

// *** testbench/cfg_front_asserts.sv ***
/* Concurrent checks on the configuration front end ports.
   Assumes it is bound to cfg_front and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module cfg_front_asserts
   import cfg_pkg::*;
#(
   parameter int POWERUP_CYCLES = 20
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [cfg_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins and outputs.
   input wire logic reset_pin,
   input wire logic serial_select_n,
   input wire logic serial_input_line,
   input wire logic power_down,
   input wire logic [1:0] clk_level,
   input wire logic [1:0] sel_level,
   input wire cfg_pkg::cfg_out_s cfg,
   input wire logic output_stable
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////
   // Cycles since reset release, saturating just past the limit.
   int unsigned up_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn) up_cnt <= 0;
      else if (up_cnt < POWERUP_CYCLES + 4) up_cnt <= up_cnt + 1;
   end
   // Strap pins held still long enough to pass the synchronisers.
   sequence strap_s;
      (reset_pin && $stable({clk_level, sel_level, power_down,
         serial_input_line}))[*6];
   endsequence
   bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   bad_read_a: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr > 8'h13 |=> s_axi_rresp == RESP_SLVERR &&
      s_axi_rdata == 32'h0) else $error("unmapped read answered");
   strap_gain_a: assert property (strap_s |->
      cfg.coarse_gain == clk_level[1] && cfg.ref_external == ^clk_level)
      else $error("clock strap decode wrong");
   strap_fmt_a: assert property (strap_s |->
      cfg.iface_cmos == sel_level[1] && cfg.straight_binary == ^sel_level)
      else $error("select strap decode wrong");
   strap_pwr_a: assert property (strap_s |->
      cfg.adc_standby == power_down && cfg.obuf_pdn == serial_input_line
      && cfg.global_pdn == (power_down && serial_input_line))
      else $error("power strap decode wrong");
   idle_cfg_a: assert property (
      (serial_select_n && !reset_pin)[*8] |-> $stable(cfg))
      else $error("config moved while deselected");
   early_a: assert property (up_cnt + 2 < POWERUP_CYCLES |->
      !output_stable) else $error("stable flag too early");
   late_a: assert property (up_cnt > POWERUP_CYCLES + 2 |->
      output_stable) else $error("stable flag too late");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (strap_s);
   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : cfg_front_asserts
`default_nettype wire

// *** testbench/cfg_front_test.sv ***
/* Self-checking bench for the configuration front end.
   Assumes the host model on the serial pins and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module cfg_front_test;
   import cfg_pkg::*;
   logic aclk, aresetn, power_down, output_stable;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, clk_level, sel_level;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic reset_pin, serial_select_n, serial_clock, serial_input_line;
   cfg_out_s cfg;
   int miscompares = 0;
   int checks = 0;
   cfg_front #(.POWERUP_CYCLES(20)) u_dut (.*, .s_axi_wstrb(4'hf));
   cfg_host_model u_host (.*);
   ////////////////////////////////////////////////////////////////
   // Clock of 40 ns period.
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic finish_test();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // One write; the response is awaited, never assumed.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk);
   endtask : wr
   // One read, judged against the expected word and response.
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, ed);
      check({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk);
   endtask : rd
   task automatic view(input logic [4:0] i, input logic [10:0] e);
      wr(OFF_VIEW_INDEX, {27'h0, i}, RESP_OKAY);
      rd(OFF_VIEW_DATA, {21'h0, e}, RESP_OKAY);
   endtask : view
   task automatic t_regs();
      rd(OFF_STATUS, 32'h1, RESP_OKAY);
      rd(OFF_CTRL, 32'h1, RESP_OKAY);
      wr(OFF_VIEW_INDEX, 32'hff, RESP_OKAY);
      rd(OFF_VIEW_INDEX, 32'h1f, RESP_OKAY);
      wr(8'h40, 32'h1, RESP_SLVERR);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(OFF_CONFIG, 32'hff, RESP_OKAY);
   endtask : t_regs
   // Every level of every strap pin, decoded through the config word.
   task automatic t_strap();
      logic [1:0] l;
      for (int i = 0; i < 4; i++) begin
         l = i[1:0];
         clk_level <= l;
         sel_level <= ~l;
         power_down <= l[0];
         u_host.set_line(l[1]);
         repeat (8) @(posedge aclk);
         rd(OFF_CONFIG, {24'h0, ^l, l[1], ^l, ~l[1], l[0], l[1], 1'b0, &l},
            RESP_OKAY);
      end
      rd(OFF_STATUS, 32'h3, RESP_OKAY);
   endtask : t_strap
   // Two words and a partial tail in one frame.
   task automatic t_serial();
      u_host.pulse_reset();
      rd(OFF_CONFIG, 32'h0, RESP_OKAY);
      u_host.send({27'h0, 16'h5400, 16'h0725, 5'h1f}, 37);
      repeat (4) @(posedge aclk);
      rd(OFF_CONFIG, 32'hfe, RESP_OKAY);
      view(5'h0a, 11'h400);
      view(5'h1f, 11'h000);
   endtask : t_serial
   task automatic t_soft();
      u_host.send({48'h0, 16'h0010}, 16);
      repeat (4) @(posedge aclk);
      rd(OFF_CONFIG, 32'h0, RESP_OKAY);
      view(5'h00, 11'h000);
      view(5'h0a, 11'h000);
   endtask : t_soft
   // Port disabled, then enabled, then a hardware reset pulse.
   task automatic t_enable();
      wr(OFF_CTRL, 32'h2, RESP_OKAY);
      rd(OFF_CTRL, 32'h0, RESP_OKAY);
      u_host.send({48'h0, 16'h0725}, 16);
      repeat (4) @(posedge aclk);
      rd(OFF_CONFIG, 32'h0, RESP_OKAY);
      wr(OFF_CTRL, 32'h1, RESP_OKAY);
      u_host.send({48'h0, 16'h0725}, 16);
      repeat (4) @(posedge aclk);
      rd(OFF_CONFIG, 32'hde, RESP_OKAY);
      rd(OFF_STATUS, 32'h102, RESP_OKAY);
      u_host.pulse_reset();
      rd(OFF_CONFIG, 32'h0, RESP_OKAY);
   endtask : t_enable
   // Main sequence after eight clocks of reset.
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, power_down} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, clk_level, sel_level} = 20'h0;
      s_axi_wdata = 32'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_strap();
      t_serial();
      t_soft();
      t_enable();
      finish_test();
   end
   // Watchdog well beyond the expected run.
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      finish_test();
   end
endmodule : cfg_front_test
bind cfg_front cfg_front_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (.*);
`default_nettype wire

// *** testbench/cfg_host_model.sv ***
/* Host controller model driving the reset and serial pins.
   Assumes the caller's tasks run just after rising edges of aclk. */
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
   // Sampling clock.
   input wire logic aclk,
   // Pins towards the converter.
   output logic reset_pin,
   output logic serial_select_n,
   output logic serial_clock,
   output logic serial_input_line
);
   // Strap mode from power-up needs no pulse.
   initial begin
      reset_pin = 1'b1;
      serial_select_n = 1'b1;
      serial_clock = 1'b0;
      serial_input_line = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   task automatic set_line(input logic v);
      serial_input_line <= v;
   endtask : set_line
   // Pulse of four clocks, then a gap before any select.
   task automatic pulse_reset();
      reset_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      reset_pin <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : pulse_reset
   // One frame, MSB first; the clock stands still outside it.
   task automatic send(input logic [63:0] bits, input int n);
      serial_select_n <= 1'b0;
      repeat (4) @(posedge aclk);
      for (int i = n - 1; i >= 0; i--) begin
         serial_input_line <= bits[i];
         serial_clock <= 1'b1;
         repeat (4) @(posedge aclk);
         serial_clock <= 1'b0;
         repeat (4) @(posedge aclk);
      end
      serial_select_n <= 1'b1;
      serial_input_line <= ~serial_input_line;
   endtask : send
endmodule : cfg_host_model
`default_nettype wire
